// >>> inc/eic_pkg.sv
/*
 Shared constants and types of the edge interval capture block.
 Assumes a single 20 MHz clock feeding every module that imports it.
*/
package eic_pkg;
   // ==========================================
   // Sizes
   localparam int NCH = 8;
   localparam int CH_W = 3;
   localparam int TS_W = 24;
   localparam int CNT_W = 16;
   localparam int N_W = 15;
   localparam int CAP_DEPTH = 800;
   localparam int PTR_W = 10;
   localparam int REC_W = CH_W + TS_W;
   localparam int WORD_W = 32;
   localparam int FIFO_DEPTH = 8;
   localparam int DIV_STEPS = TS_W;
   // ==========================================
   // Timing
   localparam int CLK_NS = 50;
   localparam int US_NS = 1000;
   localparam int US_DIV = US_NS / CLK_NS;
   localparam int MS_US = 1000;
   // ==========================================
   // Option codes and result values
   localparam logic signed [31:0] CODE_AVG = 32'sh0;
   localparam logic signed [31:0] CODE_CONT = 32'sh8000;
   localparam logic signed [31:0] CODE_TEST = -32'sh270f;
   localparam logic [WORD_W-1:0] NO_EDGE_VAL = 32'h0001869f;
   typedef enum {M_AVG, M_CONT, M_WIN, M_CAP, M_TEST} mode_t;
   typedef enum {S_IDLE, S_WIN, S_CNT, S_DIV, S_PER, S_DMP, S_TWR, S_TRD, S_SIG} state_t;
endpackage

// >>> inc/fifo_if.sv
/*
 Valid/ready carrier between the result producer and the result FIFO.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface fifo_if #(parameter int W = 32);
   logic [W-1:0] wdata;
   logic wvalid;
   logic wready;
   logic [W-1:0] rdata;
   logic rvalid;
   logic rready;
   modport wr (output wdata, output wvalid, input wready);
   modport rd (input rdata, input rvalid, output rready);
   modport fifo (input wdata, input wvalid, output wready, output rdata, output rvalid,
                 input rready);
endinterface
`default_nettype wire

// >>> src/result_fifo.sv
/*
 Flip-flop FIFO of result words, width and depth set by parameters.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
module result_fifo #(parameter int W = 32, parameter int D = 8)
(
   input wire logic mclk,
   input wire logic arst_n,
   fifo_if.fifo f
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_reg;
   logic [AW-1:0] rp_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   assign f.wready = cnt_reg != (AW+1)'(D);
   assign f.rvalid = cnt_reg != '0;
   assign f.rdata = mem[rp_reg];
   assign push = f.wvalid && f.wready;
   assign pop = f.rvalid && f.rready;

   always_ff @(posedge mclk)
   begin
      if (push)
         mem[wp_reg] <= f.wdata;
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         if (push)
            wp_reg <= (wp_reg == AW'(D - 1)) ? '0 : wp_reg + 1'b1;
         if (pop)
            rp_reg <= (rp_reg == AW'(D - 1)) ? '0 : rp_reg + 1'b1;
         if (push && !pop)
            cnt_reg <= cnt_reg + 1'b1;
         else if (pop && !push)
            cnt_reg <= cnt_reg - 1'b1;
      end
   end
endmodule
`default_nettype wire

// >>> src/edge_interval_capture_module.sv
/*
 Eight-channel edge counting, interval averaging and event capture block.
 Assumes edge inputs synchronous to mclk and a logger that drains results.
*/
`timescale 1ns/100ps
`default_nettype none
module edge_interval_capture_module
   import eic_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [NCH-1:0] edge_in,
   input wire logic cfg_valid,
   input wire logic signed [31:0] result_selection_code,
   input wire logic poll_req,
   input wire logic event_dump_trigger,
   input wire logic link_busy,
   input wire logic result_ready,
   output logic result_valid,
   output logic [WORD_W-1:0] result_data,
   output logic busy
);
   // ==========================================
   // Time base
   logic [4:0] us_div_reg;
   logic [9:0] ms_div_reg;
   logic [TS_W-1:0] ts_reg;
   logic us_tick;
   logic ms_tick;
   assign us_tick = us_div_reg == 5'(US_DIV - 1);
   assign ms_tick = us_tick && ms_div_reg == 10'(MS_US - 1);
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         us_div_reg <= '0;
         ms_div_reg <= '0;
         ts_reg <= '0;
      end
      else if (us_tick)
      begin
         us_div_reg <= '0;
         ts_reg <= ts_reg + 1'b1;
         ms_div_reg <= ms_tick ? '0 : ms_div_reg + 1'b1;
      end
      else
         us_div_reg <= us_div_reg + 1'b1;
   end

   // ==========================================
   // Option decode and configuration
   state_t state_reg;
   mode_t mode_reg;
   mode_t dec_mode;
   logic [N_W-1:0] n_reg;
   logic [N_W-1:0] dec_n;
   logic dec_ok;
   logic cfg_take;
   logic signed [31:0] neg_code;
   assign neg_code = -result_selection_code;
   always_comb
   begin
      dec_ok = 1'b1;
      dec_mode = M_AVG;
      dec_n = '0;
      if (result_selection_code == CODE_AVG)
         dec_mode = M_AVG;
      else if (result_selection_code == CODE_CONT)
         dec_mode = M_CONT;
      else if (result_selection_code == CODE_TEST)
         dec_mode = M_TEST;
      else if (result_selection_code > 0 && result_selection_code < CODE_CONT)
      begin
         dec_mode = M_WIN;
         dec_n = result_selection_code[N_W-1:0];
      end
      else if (result_selection_code < 0 && neg_code > 0 && neg_code < CODE_CONT)
      begin
         dec_mode = M_CAP;
         dec_n = neg_code[N_W-1:0];
      end
      else
         dec_ok = 1'b0;
   end
   assign cfg_take = cfg_valid && dec_ok && state_reg == S_IDLE;
   // One mode register, so every channel follows the same option
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mode_reg <= M_AVG;
         n_reg <= '0;
      end
      else if (cfg_take)
      begin
         mode_reg <= dec_mode;
         n_reg <= dec_n;
      end
   end

   // ==========================================
   // Per-channel accumulation
   logic [NCH-1:0] prev_reg;
   logic [NCH-1:0] rise;
   logic acc_en;
   logic take;
   logic acc_clr;
   logic [CNT_W-1:0] acc_cnt [NCH];
   logic [TS_W-1:0] acc_first [NCH];
   logic [TS_W-1:0] acc_last [NCH];
   logic [CNT_W-1:0] snap_cnt [NCH];
   logic [TS_W-1:0] snap_span [NCH];
   logic [N_W-1:0] win_left_reg;
   assign rise = edge_in & ~prev_reg;
   // Averaging pauses during transfers; continuous and window options keep counting, capture and self-test do not count
   assign acc_en = (mode_reg == M_AVG) ? !link_busy :
                   (mode_reg == M_CONT || mode_reg == M_WIN);
   assign take = (state_reg == S_IDLE && poll_req && !cfg_valid
                  && (mode_reg == M_AVG || mode_reg == M_CONT))
                 || (state_reg == S_WIN && ms_tick && win_left_reg <= 15'h1);
   assign acc_clr = take || (cfg_take && dec_mode == M_WIN);
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         prev_reg <= '0;
      else
         prev_reg <= edge_in;
   end
   for (genvar i = 0; i < NCH; i++)
   begin : g_ch
      always_ff @(posedge mclk or negedge arst_n)
      begin
         if (!arst_n)
         begin
            acc_cnt[i] <= '0;
            acc_first[i] <= '0;
            acc_last[i] <= '0;
            snap_cnt[i] <= '0;
            snap_span[i] <= '0;
         end
         else
         begin
            if (take)
            begin
               snap_cnt[i] <= acc_cnt[i];
               snap_span[i] <= acc_last[i] - acc_first[i];
            end
            // An edge in the clearing cycle opens the new interval
            if (acc_clr)
            begin
               acc_cnt[i] <= (rise[i] && acc_en) ? 16'h1 : '0;
               acc_first[i] <= ts_reg;
               acc_last[i] <= ts_reg;
            end
            else if (rise[i] && acc_en && acc_cnt[i] != '1)
            begin
               acc_cnt[i] <= acc_cnt[i] + 1'b1;
               if (acc_cnt[i] == '0)
                  acc_first[i] <= ts_reg;
               acc_last[i] <= ts_reg;
            end
         end
      end
   end

   // ==========================================
   // Event memory
   logic [REC_W-1:0] mem [CAP_DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] idx_reg;
   logic [N_W-1:0] c1_reg;
   logic cap_run_reg;
   logic [CH_W-1:0] first_ch;
   logic cap_wr;
   logic dmp_end;
   // Simultaneous edges keep only the lowest channel: one write per cycle
   always_comb
   begin
      first_ch = '0;
      for (int k = NCH - 1; k >= 0; k--)
         if (rise[k])
            first_ch = CH_W'(k);
   end
   assign cap_wr = cap_run_reg && rise != '0 && wr_ptr_reg != PTR_W'(CAP_DEPTH);
   assign dmp_end = state_reg == S_DMP && idx_reg == '0;
   always_ff @(posedge mclk)
   begin
      if (state_reg == S_TWR)
         mem[idx_reg] <= {idx_reg, ~idx_reg, idx_reg[6:0]};
      else if (cap_wr)
         mem[wr_ptr_reg] <= {first_ch, ts_reg};
   end
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_ptr_reg <= '0;
         c1_reg <= '0;
         cap_run_reg <= 1'b0;
      end
      else if ((cfg_take && dec_mode == M_CAP) || dmp_end)
      begin
         wr_ptr_reg <= '0;
         c1_reg <= '0;
         cap_run_reg <= 1'b1;
      end
      else if (cfg_take || state_reg == S_TWR || (cap_run_reg && c1_reg >= n_reg))
         cap_run_reg <= 1'b0;
      else if (cap_wr)
      begin
         wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (rise[0])
            c1_reg <= c1_reg + 1'b1;
      end
   end

   // ==========================================
   // Result sequencer
   fifo_if #(.W(WORD_W)) q ();
   logic [CH_W-1:0] ch_reg;
   logic [16:0] rem_reg;
   logic [TS_W-1:0] quo_reg;
   logic [4:0] step_reg;
   logic [31:0] sig_reg;
   logic [N_W-1:0] sent [NCH];
   logic [16:0] rem_s;
   logic [16:0] dvs;
   logic ge;
   logic [REC_W-1:0] rec;
   logic rec_sel;
   logic pushed;
   assign dvs = {1'b0, snap_cnt[ch_reg] - 16'h1};
   assign rem_s = {rem_reg[15:0], quo_reg[TS_W-1]};
   assign ge = rem_s >= dvs;
   assign rec = mem[idx_reg - 1'b1];
   assign rec_sel = sent[rec[REC_W-1:TS_W]] < n_reg;
   always_comb
   begin
      q.wvalid = 1'b0;
      q.wdata = '0;
      unique case (state_reg)
         S_CNT:
         begin
            q.wvalid = 1'b1;
            q.wdata = WORD_W'(snap_cnt[ch_reg]);
         end
         S_PER:
         begin
            q.wvalid = 1'b1;
            q.wdata = (snap_cnt[ch_reg] < 16'h2) ? NO_EDGE_VAL :
                      WORD_W'(quo_reg);
         end
         S_DMP:
         begin
            q.wvalid = idx_reg != '0 && rec_sel;
            q.wdata = WORD_W'(rec);
         end
         S_SIG:
         begin
            q.wvalid = 1'b1;
            q.wdata = sig_reg;
         end
         S_IDLE, S_WIN, S_DIV, S_TWR, S_TRD:
            q.wvalid = 1'b0;
      endcase
   end
   assign pushed = q.wvalid && q.wready;

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= S_IDLE;
         ch_reg <= '0;
         win_left_reg <= '0;
         idx_reg <= '0;
         sig_reg <= '0;
         rem_reg <= '0;
         quo_reg <= '0;
         step_reg <= '0;
         for (int k = 0; k < NCH; k++)
            sent[k] <= '0;
      end
      else
      unique case (state_reg)
         S_IDLE:
            if (cfg_take && dec_mode == M_WIN)
            begin
               win_left_reg <= dec_n;
               state_reg <= S_WIN;
            end
            else if (cfg_take && dec_mode == M_TEST)
            begin
               idx_reg <= '0;
               state_reg <= S_TWR;
            end
            else if (take)
            begin
               ch_reg <= '0;
               state_reg <= S_CNT;
            end
            else if (mode_reg == M_CAP && event_dump_trigger)
            begin
               idx_reg <= wr_ptr_reg;
               for (int k = 0; k < NCH; k++)
                  sent[k] <= '0;
               state_reg <= S_DMP;
            end
         S_WIN:
            if (ms_tick)
            begin
               win_left_reg <= win_left_reg - 1'b1;
               if (take)
               begin
                  ch_reg <= '0;
                  state_reg <= S_CNT;
               end
            end
         S_CNT:
            if (pushed)
            begin
               rem_reg <= '0;
               quo_reg <= snap_span[ch_reg];
               step_reg <= '0;
               state_reg <= (snap_cnt[ch_reg] < 16'h2) ? S_PER : S_DIV;
            end
         S_DIV:
         begin
            rem_reg <= ge ? rem_s - dvs : rem_s;
            quo_reg <= {quo_reg[TS_W-2:0], ge};
            step_reg <= step_reg + 1'b1;
            if (step_reg == 5'(DIV_STEPS - 1))
               state_reg <= S_PER;
         end
         S_PER:
            if (pushed)
            begin
               ch_reg <= ch_reg + 1'b1;
               state_reg <= (ch_reg == CH_W'(NCH - 1)) ? S_IDLE : S_CNT;
            end
         S_DMP:
            if (idx_reg == '0)
               state_reg <= S_IDLE;
            else if (pushed || !rec_sel)
            begin
               idx_reg <= idx_reg - 1'b1;
               if (rec_sel)
                  sent[rec[REC_W-1:TS_W]] <= sent[rec[REC_W-1:TS_W]] + 1'b1;
            end
         S_TWR:
            if (idx_reg == PTR_W'(CAP_DEPTH - 1))
            begin
               idx_reg <= '0;
               sig_reg <= '0;
               state_reg <= S_TRD;
            end
            else
               idx_reg <= idx_reg + 1'b1;
         S_TRD:
         begin
            sig_reg <= {sig_reg[30:0], sig_reg[31]} ^ WORD_W'(mem[idx_reg]);
            idx_reg <= idx_reg + 1'b1;
            if (idx_reg == PTR_W'(CAP_DEPTH - 1))
               state_reg <= S_SIG;
         end
         S_SIG:
            if (pushed)
               state_reg <= S_IDLE;
      endcase
   end

   // ==========================================
   // Output stage; the FIFO lets the logger stall the sequencer
   result_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .arst_n(arst_n),
      .f(q)
   );
   assign q.rready = !result_valid || result_ready;
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         result_valid <= 1'b0;
         result_data <= '0;
         busy <= 1'b0;
      end
      else
      begin
         busy <= state_reg != S_IDLE;
         if (q.rready)
         begin
            result_valid <= q.rvalid;
            result_data <= q.rdata;
         end
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // Self-test span is too long for a delay range, so it is counted here
   logic [10:0] test_cyc_reg;
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         test_cyc_reg <= '0;
      else if (state_reg == S_TWR || state_reg == S_TRD)
         test_cyc_reg <= test_cyc_reg + 1'b1;
      else
         test_cyc_reg <= '0;
   end
   sequence s_win_end;
      state_reg == S_WIN && ms_tick && win_left_reg == 15'h1;
   endsequence
   property p_zero_cnt;
      state_reg == S_CNT && snap_cnt[ch_reg] == '0 |-> q.wdata == '0;
   endproperty
   a_zero_cnt: assert property (p_zero_cnt) else $error("count not zero");
   property p_no_edge;
      state_reg == S_PER && snap_cnt[ch_reg] == '0 |-> q.wdata == NO_EDGE_VAL;
   endproperty
   a_no_edge: assert property (p_no_edge) else $error("missing 99999");
   property p_pause;
      mode_reg == M_AVG && link_busy && !acc_clr |=> $stable(acc_cnt[0]);
   endproperty
   a_pause: assert property (p_pause) else $error("counted while busy");
   property p_cont;
      mode_reg == M_CONT && rise[0] && !acc_clr && acc_cnt[0] != '1
      |=> acc_cnt[0] == $past(acc_cnt[0]) + 16'h1;
   endproperty
   a_cont: assert property (p_cont) else $error("edge missed");
   property p_win;
      s_win_end |=> state_reg == S_CNT && ch_reg == '0;
   endproperty
   a_win: assert property (p_win) else $error("window end wrong");
   property p_cap_stop;
      cap_run_reg && c1_reg >= n_reg && !dmp_end && !(cfg_take && dec_mode == M_CAP)
      |=> !cap_run_reg;
   endproperty
   a_cap_stop: assert property (p_cap_stop) else $error("capture ran on");
   property p_dump_clr;
      dmp_end |=> wr_ptr_reg == '0 && cap_run_reg && state_reg == S_IDLE;
   endproperty
   a_dump_clr: assert property (p_dump_clr) else $error("memory not reset");
   property p_test;
      cfg_take && dec_mode == M_TEST |=> state_reg == S_TWR && test_cyc_reg == '0;
   endproperty
   a_test: assert property (p_test) else $error("self-test sequence");
   property p_test_len;
      state_reg == S_SIG && $past(state_reg) == S_TRD |-> test_cyc_reg == 11'(2 * CAP_DEPTH);
   endproperty
   a_test_len: assert property (p_test_len) else $error("self-test length wrong");
   property p_bad_code;
      cfg_valid && !dec_ok |=> $stable(mode_reg) && $stable(n_reg);
   endproperty
   a_bad_code: assert property (p_bad_code) else $error("bad code changed mode");
endmodule
`default_nettype wire

// >>> verif/logger_model.sv
/*
 Logger side model: drains result words into a queue, promptly or with random stalls.
 Assumes the result port of the capture block on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module logger_model
   import eic_pkg::*;
(
   input wire logic mclk,
   input wire logic result_valid,
   input wire logic [WORD_W-1:0] result_data,
   input wire logic slow,
   output logic result_ready
);
   logic [WORD_W-1:0] rx_q[$];
   logic [7:0] lfsr_reg = 8'h5b;
   initial result_ready = 1'b0;
   // ==========================================
   // Take a word only at an edge where ready is high
   always @(posedge mclk)
   begin
      if (result_valid && result_ready)
      begin
         rx_q.push_back(result_data);
      end
   end
   // Ready moves half a cycle away from the sampling edge
   always @(negedge mclk)
   begin
      lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
      result_ready <= !slow || lfsr_reg[0];
   end
endmodule
`default_nettype wire

// >>> verif/edge_interval_capture_module_tb_top.sv
/*
 Self-checking bench of the edge interval capture block with a logger model.
 Assumes the design package and a single 20 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module edge_interval_capture_module_tb_top
   import eic_pkg::*;
;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [NCH-1:0] edge_in = '0;
   logic cfg_valid = 1'b0;
   logic signed [31:0] result_selection_code = 32'sh0;
   logic poll_req = 1'b0;
   logic event_dump_trigger = 1'b0;
   logic link_busy = 1'b0;
   logic slow = 1'b0;
   logic result_ready;
   logic result_valid;
   logic [WORD_W-1:0] result_data;
   logic busy;
   int mismatches = 0;
   int num_checks = 0;
   logic [31:0] seed = 32'ha5179f3b;
   int cnt[NCH];
   int first[NCH];
   int last[NCH];
   int per[NCH];
   logic [WORD_W-1:0] exp_q[$];

   always #25 mclk = ~mclk;

   edge_interval_capture_module i_dut (.mclk(mclk), .arst_n(arst_n), .edge_in(edge_in),
      .cfg_valid(cfg_valid), .result_selection_code(result_selection_code),
      .poll_req(poll_req), .event_dump_trigger(event_dump_trigger), .link_busy(link_busy),
      .result_ready(result_ready), .result_valid(result_valid), .result_data(result_data),
      .busy(busy));
   logger_model i_logger (.mclk(mclk), .result_valid(result_valid),
      .result_data(result_data), .slow(slow), .result_ready(result_ready));

   // ==========================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
      begin
         $display("verification passed");
      end
      else
      begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cfg(input logic signed [31:0] v);
      @(negedge mclk);
      result_selection_code = v;
      cfg_valid = 1'b1;
      @(negedge mclk);
      cfg_valid = 1'b0;
   endtask

   task automatic req(input int k);
      @(negedge mclk);
      poll_req = (k == 0);
      event_dump_trigger = (k == 1);
      @(negedge mclk);
      poll_req = 1'b0;
      event_dump_trigger = 1'b0;
   endtask

   // Periods are whole microseconds so timestamp differences are exact
   task automatic run_edges(input int n, input int ba, input int bb, input bit pause);
      for (int c = 0; c < NCH; c++)
      begin
         seed = xs(seed);
         per[c] = int'(seed[2:0]) + 1;
      end
      for (int t = 0; t < n; t++)
      begin
         @(negedge mclk);
         link_busy = (t >= ba && t < bb);
         for (int c = 0; c < NCH; c++)
         begin
            edge_in[c] = (t % (20 * per[c])) < 10;
            if (t % (20 * per[c]) == 0 && !(pause && link_busy))
            begin
               if (cnt[c] == 0)
                  first[c] = t;
               last[c] = t;
               cnt[c]++;
            end
         end
      end
      @(negedge mclk);
      edge_in = '0;
      link_busy = 1'b0;
   endtask

   task automatic expect_avg;
      for (int c = 0; c < NCH; c++)
      begin
         exp_q.push_back(cnt[c]);
         exp_q.push_back(cnt[c] < 2 ? NO_EDGE_VAL : (last[c] - first[c]) / 20 / (cnt[c] - 1));
         cnt[c] = 0;
      end
   endtask

   // Quiet for 40 cycles covers the divide gap between two words
   task automatic settle;
      int q;
      q = 0;
      for (int i = 0; i < 60000 && q < 40; i++)
      begin
         @(negedge mclk);
         q = (busy === 1'b0 && result_valid === 1'b0) ? q + 1 : 0;
      end
   endtask

   task automatic compare(input string name);
      settle;
      chk(i_logger.rx_q.size(), exp_q.size());
      for (int i = 0; i < exp_q.size() && i < i_logger.rx_q.size(); i++)
         chk(i_logger.rx_q[i], exp_q[i]);
      i_logger.rx_q.delete();
      exp_q.delete();
      $display("test %s done", name);
   endtask

   // ==========================================
   // Watchdog
   initial
   begin
      #(90000 * CLK_NS);
      mismatches++;
      $display("[FAIL] %0t ns: watchdog expired", $time);
      end_of_test;
   end

   // ==========================================
   // Tests
   initial
   begin
      int t;
      int n1;
      int cq[$];
      int tq[$];
      int ev[8] = '{0, 1, 0, 2, 1, 0, 1, 0};
      logic [31:0] sig;
      repeat (5) @(negedge mclk);
      chk(result_data, '0);
      chk({busy, result_valid}, '0);
      arst_n = 1'b1;
      req(0);
      expect_avg;
      compare("idle poll");
      slow = 1'b1;
      run_edges(1600, 315, 715, 1);
      req(0);
      expect_avg;
      compare("average");
      slow = 1'b0;
      cfg(CODE_CONT);
      run_edges(1600, 315, 715, 0);
      req(0);
      expect_avg;
      compare("continuous");
      cfg(32'sd40000);
      cfg(-32'sd40000);
      repeat (50) @(negedge mclk);
      chk({busy, result_valid}, '0);
      run_edges(1600, 315, 715, 0);
      req(0);
      expect_avg;
      compare("bad code");
      // Window of 2 ms; its first millisecond may be partial
      cfg(32'sd2);
      run_edges(40000, 0, 0, 0);
      settle;
      chk(i_logger.rx_q.size(), 16);
      for (int c = 0; c < NCH && i_logger.rx_q.size() == 16; c++)
      begin
         num_checks++;
         if ((i_logger.rx_q[2*c] >= 1000 / per[c]
              && i_logger.rx_q[2*c] <= 2000 / per[c] + 1) !== 1'b1)
         begin
            mismatches++;
            $display("[FAIL] %0t ns: window count %0d off", $time, i_logger.rx_q[2*c]);
         end
         chk(i_logger.rx_q[2*c+1], per[c]);
         cnt[c] = 0;
      end
      i_logger.rx_q.delete();
      $display("test window done");
      cfg(-32'sd3);
      repeat (5) @(negedge mclk);
      t = 0;
      n1 = 0;
      foreach (ev[i])
      begin
         if (n1 < 3)
         begin
            cq.push_front(ev[i]);
            tq.push_front(t);
            n1 += (ev[i] == 0);
         end
         edge_in[ev[i]] = 1'b1;
         repeat (10) @(negedge mclk);
         edge_in = '0;
         repeat (50) @(negedge mclk);
         t += 60;
      end
      req(1);
      settle;
      chk(i_logger.rx_q.size(), cq.size());
      for (int i = 0; i < cq.size() && i < i_logger.rx_q.size(); i++)
      begin
         chk(i_logger.rx_q[i][31:24], cq[i]);
         if (i > 0)
            chk(i_logger.rx_q[i-1][23:0] - i_logger.rx_q[i][23:0],
                (tq[i-1] - tq[i]) / 20);
      end
      i_logger.rx_q.delete();
      req(1);
      compare("capture");
      // Signature: rotate left, then fold in each read-back pattern {idx, ~idx, idx[6:0]}
      sig = '0;
      for (int i = 0; i < CAP_DEPTH; i++)
         sig = {sig[30:0], sig[31]} ^ {5'h0, 10'(i), ~10'(i), 7'(i)};
      exp_q.push_back(sig);
      cfg(CODE_TEST);
      compare("self test");
      end_of_test;
   end
endmodule
`default_nettype wire
